//--- pkg/uhl_map.svh
// register offsets, field positions and reset values of the list-pointer bank
`ifndef UHL_MAP_SVH
`define UHL_MAP_SVH

`define UHL_ADDR_W          12
`define UHL_OFF_LIST_CTRL   12'h400
`define UHL_OFF_COMMAND     12'h408
`define UHL_OFF_EVENT       12'h40C
`define UHL_OFF_COMM_AREA   12'h418
`define UHL_OFF_PERIODIC    12'h41C
`define UHL_OFF_CTRL_HEAD   12'h420
`define UHL_OFF_CTRL_CUR    12'h424
`define UHL_OFF_BULK_HEAD   12'h428
`define UHL_OFF_BULK_CUR    12'h42C
`define UHL_OFF_DONE_HEAD   12'h430
`define UHL_OFF_FRAME_IVL   12'h434
`define UHL_OFF_FRAME_REM   12'h438

`define UHL_BIT_CTRL_ON     4
`define UHL_BIT_BULK_ON     5
`define UHL_BIT_SOFT_RESET  0
`define UHL_BIT_CTRL_FILLED 1
`define UHL_BIT_BULK_FILLED 2
`define UHL_BIT_DONE_WRITTEN 1

`define UHL_FI_TOGGLE       31
`define UHL_FI_LP_HI        30
`define UHL_FI_LP_LO        16
`define UHL_FI_IVL_HI       13
`define UHL_FI_RESET        32'h0000_2EDF

`endif

//--- pkg/uhl_pkg.sv
// types of the list-pointer and frame-interval register bank
package uhl_pkg;
`include "uhl_map.svh"

    typedef logic [27:0] uhl_ptr_type;

    typedef struct packed {
        logic [23:0] comm_area;
        uhl_ptr_type periodic_cur;
        uhl_ptr_type control_head;
        uhl_ptr_type control_cur;
        uhl_ptr_type bulk_head;
        uhl_ptr_type bulk_cur;
        uhl_ptr_type done_head;
        logic        fi_toggle;
        logic [14:0] fi_largest;
        logic [13:0] fi_interval;
        logic        fr_toggle;
        logic [13:0] fr_count;
        logic [14:0] largest_count;
        logic        control_on;
        logic        bulk_on;
        logic        control_filled;
        logic        bulk_filled;
        logic        done_written;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
        logic        link_valid;
        uhl_ptr_type link_td;
        uhl_ptr_type link_next;
        logic        area_valid;
        uhl_ptr_type area_data;
        logic        sof;
    } uhl_state_type;

endpackage

//--- core/uhl_regs.sv
// list-pointer, done-queue and frame-interval registers behind an APB slave
//
// Behaviour
// - communication-area base keeps bits 7:0 at zero on every read
// - periodic current pointer follows the engine; software reads it only
// - all descriptor pointer registers hold bits 3:0 at zero
// - control head holds first control descriptor; traversal restarts from it
// - control current advances per served descriptor, resumes next frame
// - control list end: if filled, copy head into current, clear flag
// - control current resets to zero; zero marks the list end
// - bulk head holds first bulk descriptor; traversal restarts from it
// - bulk current advances; at list end reload from head if filled
// - completed descriptor gets old done head, then done head takes it
// - done-head write-back clears the register and sets the written flag
// - largest-packet field loads the packet counter at each frame start
// - frame interval in bit times, resets to 11,999 (0x2EDF)
// - controller soft reset restores the nominal frame interval
// - frame-remaining toggle is loaded from the interval toggle
// - that toggle copy happens on the bit tick that reloads the remaining count from zero
// - remaining count decrements per bit time, reloads interval at zero
//
// Local design decision: the APB slave port.
`include "uhl_map.svh"
module uhl_regs
    import uhl_pkg::*;
(
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [`UHL_ADDR_W-1:0]  paddr,
    input  wire logic [31:0]             pwdata,
    output logic      [31:0]             prdata,
    output logic                         pready,
    output logic                         pslverr,
    input  wire logic                    periodic_update,
    input  wire logic [31:0]             periodic_next,
    input  wire logic                    control_served,
    input  wire logic [31:0]             control_next,
    input  wire logic                    bulk_served,
    input  wire logic [31:0]             bulk_next,
    input  wire logic                    td_done,
    input  wire logic [31:0]             td_addr,
    input  wire logic                    done_writeback,
    input  wire logic                    bit_tick,
    output logic      [31:0]             comm_area_base,
    output logic      [31:0]             periodic_ptr,
    output logic      [31:0]             control_head_ptr,
    output logic      [31:0]             control_ptr,
    output logic      [31:0]             bulk_head_ptr,
    output logic      [31:0]             bulk_ptr,
    output logic                         control_list_on,
    output logic                         bulk_list_on,
    output logic                         link_write,
    output logic      [31:0]             link_td_addr,
    output logic      [31:0]             link_value,
    output logic                         area_done_write,
    output logic      [31:0]             area_done_value,
    output logic                         done_head_written,
    output logic                         sof_pulse,
    output logic      [14:0]             largest_packet_count,
    output logic      [13:0]             frame_bits_left
);

    uhl_state_type state_reg;
    uhl_state_type state_next;

    logic access;
    logic commit;
    logic wr;

    // one decoder for write gating and the error answer; read data has its own case
    function automatic logic uhl_mapped(input logic [`UHL_ADDR_W-1:0] a);
        case (a)
            `UHL_OFF_LIST_CTRL, `UHL_OFF_COMMAND, `UHL_OFF_EVENT,
            `UHL_OFF_COMM_AREA, `UHL_OFF_PERIODIC, `UHL_OFF_CTRL_HEAD,
            `UHL_OFF_CTRL_CUR, `UHL_OFF_BULK_HEAD, `UHL_OFF_BULK_CUR,
            `UHL_OFF_DONE_HEAD, `UHL_OFF_FRAME_IVL,
            `UHL_OFF_FRAME_REM: uhl_mapped = 1'b1;
            default: uhl_mapped = 1'b0;
        endcase
    endfunction

    function automatic logic [31:0] uhl_read(
        input uhl_state_type            s,
        input logic [`UHL_ADDR_W-1:0]   a
    );
        logic [31:0] d;
        d = 32'h0000_0000;
        case (a)
            `UHL_OFF_LIST_CTRL: begin
                d[`UHL_BIT_CTRL_ON] = s.control_on;
                d[`UHL_BIT_BULK_ON] = s.bulk_on;
            end
            `UHL_OFF_COMMAND: begin
                d[`UHL_BIT_CTRL_FILLED] = s.control_filled;
                d[`UHL_BIT_BULK_FILLED] = s.bulk_filled;
            end
            `UHL_OFF_EVENT: d[`UHL_BIT_DONE_WRITTEN] = s.done_written;
            `UHL_OFF_COMM_AREA: d = {s.comm_area, 8'h00};
            `UHL_OFF_PERIODIC:  d = {s.periodic_cur, 4'h0};
            `UHL_OFF_CTRL_HEAD: d = {s.control_head, 4'h0};
            `UHL_OFF_CTRL_CUR:  d = {s.control_cur, 4'h0};
            `UHL_OFF_BULK_HEAD: d = {s.bulk_head, 4'h0};
            `UHL_OFF_BULK_CUR:  d = {s.bulk_cur, 4'h0};
            `UHL_OFF_DONE_HEAD: d = {s.done_head, 4'h0};
            `UHL_OFF_FRAME_IVL: begin
                d[`UHL_FI_TOGGLE] = s.fi_toggle;
                d[`UHL_FI_LP_HI:`UHL_FI_LP_LO] = s.fi_largest;
                d[`UHL_FI_IVL_HI:0] = s.fi_interval;
            end
            `UHL_OFF_FRAME_REM: begin
                d[`UHL_FI_TOGGLE] = s.fr_toggle;
                d[`UHL_FI_IVL_HI:0] = s.fr_count;
            end
            default: d = 32'h0000_0000;
        endcase
        uhl_read = d;
    endfunction

    // one wait state: data and pready are both registered
    assign access = psel & penable & ~state_reg.pready;
    assign commit = psel & penable & state_reg.pready;
    assign wr     = commit & pwrite & uhl_mapped(paddr);

    always_comb begin
        state_next = state_reg;
        state_next.pready = 1'b0;
        state_next.pslverr = 1'b0;
        state_next.link_valid = 1'b0;
        state_next.area_valid = 1'b0;
        state_next.sof = 1'b0;

        if (access) begin
            state_next.pready = 1'b1;
            state_next.pslverr = ~uhl_mapped(paddr);
            state_next.prdata = uhl_read(state_reg, paddr);
        end

        // software side first, so engine events in the same cycle win, except over a filled mark written by software
        if (wr) begin
            case (paddr)
                `UHL_OFF_LIST_CTRL: begin
                    state_next.control_on = pwdata[`UHL_BIT_CTRL_ON];
                    state_next.bulk_on = pwdata[`UHL_BIT_BULK_ON];
                end
                `UHL_OFF_COMMAND: begin
                    state_next.control_filled =
                        pwdata[`UHL_BIT_CTRL_FILLED];
                    state_next.bulk_filled = pwdata[`UHL_BIT_BULK_FILLED];
                    // reset completes in one cycle, so the bit reads 0
                    if (pwdata[`UHL_BIT_SOFT_RESET]) begin
                        state_next.fi_toggle = 1'b0;
                        state_next.fi_largest = 15'h0000;
                        state_next.fi_interval =
                            14'(`UHL_FI_RESET);
                        state_next.fr_toggle = 1'b0;
                        state_next.fr_count = 14'h0000;
                    end
                end
                `UHL_OFF_EVENT: begin
                    if (pwdata[`UHL_BIT_DONE_WRITTEN]) begin
                        state_next.done_written = 1'b0;
                    end
                end
                `UHL_OFF_COMM_AREA: begin
                    state_next.comm_area = pwdata[31:8];
                end
                `UHL_OFF_CTRL_HEAD: begin
                    state_next.control_head = pwdata[31:4];
                end
                `UHL_OFF_CTRL_CUR: begin
                    // a running list owns its pointer
                    if (!state_reg.control_on) begin
                        state_next.control_cur = pwdata[31:4];
                    end
                end
                `UHL_OFF_BULK_HEAD: begin
                    state_next.bulk_head = pwdata[31:4];
                end
                `UHL_OFF_BULK_CUR: begin
                    if (!state_reg.bulk_on) begin
                        state_next.bulk_cur = pwdata[31:4];
                    end
                end
                `UHL_OFF_FRAME_IVL: begin
                    state_next.fi_toggle = pwdata[`UHL_FI_TOGGLE];
                    state_next.fi_largest =
                        pwdata[`UHL_FI_LP_HI:`UHL_FI_LP_LO];
                    state_next.fi_interval = pwdata[`UHL_FI_IVL_HI:0];
                end
                // periodic, done head and remaining are read only
                default: state_next.prdata = state_next.prdata;
            endcase
        end

        if (periodic_update) begin
            state_next.periodic_cur = periodic_next[31:4];
        end

        if (control_served) begin
            if (control_next[31:4] != 28'h0000000) begin
                state_next.control_cur = control_next[31:4];
            end else if (state_reg.control_filled) begin
                state_next.control_cur = state_reg.control_head;
                state_next.control_filled = 1'b0;
            end else begin
                state_next.control_cur = 28'h0000000;
            end
        end

        if (bulk_served) begin
            if (bulk_next[31:4] != 28'h0000000) begin
                state_next.bulk_cur = bulk_next[31:4];
            end else if (state_reg.bulk_filled) begin
                state_next.bulk_cur = state_reg.bulk_head;
                state_next.bulk_filled = 1'b0;
            end else begin
                state_next.bulk_cur = 28'h0000000;
            end
        end

        // a new write-back is dropped until software has cleared the flag
        if (done_writeback && !state_reg.done_written) begin
            state_next.area_valid = 1'b1;
            state_next.area_data = state_reg.done_head;
            state_next.done_head = 28'h0000000;
            state_next.done_written = 1'b1;
        end

        // follows the write-back, so it links to the emptied queue
        if (td_done) begin
            state_next.link_valid = 1'b1;
            state_next.link_td = td_addr[31:4];
            state_next.link_next = state_next.done_head;
            state_next.done_head = td_addr[31:4];
        end

        if (bit_tick) begin
            if (state_reg.fr_count == 14'h0000) begin
                state_next.fr_count = state_reg.fi_interval;
                state_next.fr_toggle = state_reg.fi_toggle;
                state_next.largest_count = state_reg.fi_largest;
                state_next.sof = 1'b1;
            end else begin
                state_next.fr_count = state_reg.fr_count - 14'h0001;
            end
        end

        // a filled mark written by software beats the engine's clear
        if (wr && paddr == `UHL_OFF_COMMAND) begin
            if (pwdata[`UHL_BIT_CTRL_FILLED]) begin
                state_next.control_filled = 1'b1;
            end
            if (pwdata[`UHL_BIT_BULK_FILLED]) begin
                state_next.bulk_filled = 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= '0;
            state_reg.fi_interval <= 14'(`UHL_FI_RESET);
        end else begin
            state_reg <= state_next;
        end
    end

    assign prdata               = state_reg.prdata;
    assign pready               = state_reg.pready;
    assign pslverr              = state_reg.pslverr;
    assign comm_area_base       = {state_reg.comm_area, 8'h00};
    assign periodic_ptr         = {state_reg.periodic_cur, 4'h0};
    assign control_head_ptr     = {state_reg.control_head, 4'h0};
    assign control_ptr          = {state_reg.control_cur, 4'h0};
    assign bulk_head_ptr        = {state_reg.bulk_head, 4'h0};
    assign bulk_ptr             = {state_reg.bulk_cur, 4'h0};
    assign control_list_on      = state_reg.control_on;
    assign bulk_list_on         = state_reg.bulk_on;
    assign link_write           = state_reg.link_valid;
    assign link_td_addr         = {state_reg.link_td, 4'h0};
    assign link_value           = {state_reg.link_next, 4'h0};
    assign area_done_write      = state_reg.area_valid;
    assign area_done_value      = {state_reg.area_data, 4'h0};
    assign done_head_written    = state_reg.done_written;
    assign sof_pulse            = state_reg.sof;
    assign largest_packet_count = state_reg.largest_count;
    assign frame_bits_left      = state_reg.fr_count;

endmodule

//--- dv/uhl_regs_assertions.sv
// concurrent checks on the ports of the list-pointer register bank
module uhl_regs_assertions (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        pwrite,
    input wire logic        pready,
    input wire logic        control_served,
    input wire logic [31:0] control_next,
    input wire logic [31:0] control_ptr,
    input wire logic        control_list_on,
    input wire logic        td_done,
    input wire logic [31:0] td_addr,
    input wire logic        done_writeback,
    input wire logic        link_write,
    input wire logic [31:0] link_td_addr,
    input wire logic [31:0] link_value,
    input wire logic        area_done_write,
    input wire logic        done_head_written,
    input wire logic        bit_tick,
    input wire logic [13:0] frame_bits_left,
    input wire logic        sof_pulse,
    input wire logic [31:0] comm_area_base
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence td_alone;
        td_done && !done_writeback;
    endsequence
    sequence td_pair;
        td_alone ##1 td_alone;
    endsequence
    a_comm_aligned: assert property (comm_area_base[7:0] == 8'h00)
        else $error("comm area base low byte not zero");
    a_ctrl_advance: assert property (
        control_served && control_next != 32'h0
        |=> control_ptr == ($past(control_next) & 32'hFFFF_FFF0))
        else $error("control current did not advance");
    a_ctrl_locked: assert property (
        control_list_on && !control_served |=> $stable(control_ptr))
        else $error("control current changed while list on");
    a_td_link: assert property (
        td_alone |=> link_write
        && link_td_addr == ($past(td_addr) & 32'hFFFF_FFF0))
        else $error("completed descriptor not linked");
    a_link_chain: assert property (
        td_pair |=> link_value == $past(link_td_addr))
        else $error("second descriptor not linked to first");
    a_wb_once: assert property (
        done_writeback && !done_head_written
        |=> area_done_write && done_head_written ##1 !area_done_write)
        else $error("write-back pulse or flag wrong");
    a_wb_refused: assert property (
        done_writeback && done_head_written |=> !area_done_write)
        else $error("write-back taken while flag set");
    // a tick in the same cycle beats the soft-reset clear of the count; write cycles are skipped all the same
    a_frame_count: assert property (
        bit_tick && !(pready && pwrite) && frame_bits_left != 14'h0
        |=> !sof_pulse && frame_bits_left == $past(frame_bits_left) - 14'h1)
        else $error("frame count did not step down");
endmodule

bind uhl_regs uhl_regs_assertions u_uhl_regs_assertions (
    .pclk(pclk), .presetn(presetn), .pwrite(pwrite), .pready(pready),
    .control_served(control_served), .control_next(control_next),
    .control_ptr(control_ptr), .control_list_on(control_list_on),
    .td_done(td_done), .td_addr(td_addr), .done_writeback(done_writeback),
    .link_write(link_write), .link_td_addr(link_td_addr),
    .link_value(link_value), .area_done_write(area_done_write),
    .done_head_written(done_head_written), .bit_tick(bit_tick),
    .frame_bits_left(frame_bits_left), .sof_pulse(sof_pulse),
    .comm_area_base(comm_area_base)
);

//--- dv/uhl_engine_model.sv
// engine-side model: drives list and frame events, records write-backs
module uhl_engine_model (
    input  wire logic        pclk,
    output logic             periodic_update,
    output logic             control_served,
    output logic             bulk_served,
    output logic             td_done,
    output logic             done_writeback,
    output logic             bit_tick,
    output logic [31:0]      periodic_next,
    output logic [31:0]      control_next,
    output logic [31:0]      bulk_next,
    output logic [31:0]      td_addr,
    input  wire logic        link_write,
    input  wire logic [31:0] link_value,
    input  wire logic        area_done_write,
    input  wire logic [31:0] area_done_value,
    input  wire logic        sof_pulse
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [5:0]  pulse = 6'h00;
    logic [31:0] nxt = 32'h0;
    logic [31:0] lnk = 32'h0;
    logic [31:0] area_val = 32'h0;
    int          area_cnt = 0;
    int          sof_cnt = 0;
    assign {bit_tick, done_writeback, td_done, bulk_served, control_served,
            periodic_update} = pulse;
    // one shared address bus: only the pulsed event's copy is meaningful
    assign {periodic_next, control_next, bulk_next, td_addr} = {4{nxt}};
    always @(posedge pclk) begin
        if (link_write)
            lnk <= link_value;
        if (area_done_write) begin
            area_val <= area_done_value;
            area_cnt <= area_cnt + 1;
        end
        if (sof_pulse)
            sof_cnt <= sof_cnt + 1;
    end
    // kinds: 0 periodic, 1 control, 2 bulk, 3 td done, 4 write-back, 5 bit
    // a zero next address ends a list; two keeps the pulse a second beat
    task automatic ev(input int k, input logic [31:0] a,
                      input logic two = 1'b0, input logic [31:0] b = 32'h0);
        @(posedge pclk);
        pulse <= 6'(1 << k);
        nxt   <= a;
        if (two) begin
            @(posedge pclk);
            nxt <= b;
        end
        @(posedge pclk);
        pulse <= 6'h00;
        // released lines carry garbage so a stale address cannot pass
        nxt   <= ~nxt;
    endtask
endmodule

//--- dv/test_usb_host_list_pointer_frame_regs.sv
// self-checking bench for the list-pointer and frame-interval registers
module test_usb_host_list_pointer_frame_regs;
    timeunit 1ns;
    timeprecision 100ps;
    logic        pclk = 1'b0, presetn = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, er;
    logic        periodic_update, control_served, bulk_served;
    logic        td_done, done_writeback, bit_tick;
    logic [31:0] periodic_next, control_next, bulk_next, td_addr;
    logic        link_write, area_done_write, sof_pulse;
    logic [31:0] link_value, area_done_value;
    logic [31:0] periodic_ptr, control_head_ptr, bulk_head_ptr, bulk_ptr;
    logic        control_list_on, bulk_list_on;
    logic [14:0] largest_packet_count;
    int          fails = 0, cmp_count = 0;

    uhl_regs u_uhl_regs (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr),
        .periodic_update(periodic_update), .periodic_next(periodic_next),
        .control_served(control_served), .control_next(control_next),
        .bulk_served(bulk_served), .bulk_next(bulk_next),
        .td_done(td_done), .td_addr(td_addr),
        .done_writeback(done_writeback), .bit_tick(bit_tick),
        .comm_area_base(), .periodic_ptr(periodic_ptr),
        .control_head_ptr(control_head_ptr), .control_ptr(),
        .bulk_head_ptr(bulk_head_ptr), .bulk_ptr(bulk_ptr),
        .control_list_on(control_list_on), .bulk_list_on(bulk_list_on),
        .link_write(link_write), .link_td_addr(), .link_value(link_value),
        .area_done_write(area_done_write),
        .area_done_value(area_done_value), .done_head_written(),
        .sof_pulse(sof_pulse), .largest_packet_count(largest_packet_count),
        .frame_bits_left()
    );
    uhl_engine_model u_uhl_engine_model (
        .pclk(pclk), .periodic_update(periodic_update),
        .control_served(control_served), .bulk_served(bulk_served),
        .td_done(td_done), .done_writeback(done_writeback),
        .bit_tick(bit_tick), .periodic_next(periodic_next),
        .control_next(control_next), .bulk_next(bulk_next),
        .td_addr(td_addr), .link_write(link_write), .link_value(link_value),
        .area_done_write(area_done_write),
        .area_done_value(area_done_value), .sof_pulse(sof_pulse)
    );

    always #2 pclk = ~pclk;

    task automatic conclude;
        if (fails == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n = 0;
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            fails++;
            conclude();
        end
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd_chk(input string nm, input logic [11:0] a,
                          input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(nm, rd, exp);
    endtask
    task automatic wr_chk(input string nm, input logic [11:0] a,
                          input logic [31:0] d, exp);
        apb(1'b1, a, d);
        rd_chk(nm, a, exp);
    endtask

    task automatic t_reset;
        for (int i = 0; i < 8; i++) begin
            rd_chk("reset", 12'h41C + 12'(4 * i),
                   (i == 6) ? 32'h0000_2EDF : 32'h0);
        end
        apb(1'b1, 12'h500, 32'hFFFF_FFFF);
        chk("unmapped error", {31'h0, er}, 32'h1);
        rd_chk("unmapped read", 12'h500, 32'h0);
    endtask
    task automatic t_masks;
        wr_chk("comm area", 12'h418, '1, 32'hFFFF_FF00);
        wr_chk("ctrl head", 12'h420, '1, 32'hFFFF_FFF0);
        wr_chk("bulk head", 12'h428, 32'h5A5F, 32'h5A50);
        wr_chk("periodic ro", 12'h41C, '1, 32'h0);
        wr_chk("done ro", 12'h430, '1, 32'h0);
        u_uhl_engine_model.ev(0, 32'h300F);
        rd_chk("periodic", 12'h41C, 32'h3000);
        chk("periodic out", periodic_ptr, 32'h0000_3000);
        chk("ctrl head out", control_head_ptr, 32'hFFFF_FFF0);
        chk("bulk head out", bulk_head_ptr, 32'h0000_5A50);
    endtask
    task automatic t_gate;
        wr_chk("ccur off", 12'h424, 32'h1234_5678, 32'h1234_5670);
        wr_chk("bcur off", 12'h42C, 32'h0104, 32'h0100);
        apb(1'b1, 12'h400, 32'h30);
        wr_chk("ccur on", 12'h424, 32'hABCD_EF00, 32'h1234_5670);
        wr_chk("bcur on", 12'h42C, 32'hABCD_EF00, 32'h0100);
        chk("lists on", {30'h0, bulk_list_on, control_list_on},
            32'h3);
    endtask
    task automatic t_lists;
        u_uhl_engine_model.ev(1, 32'h2000);
        rd_chk("ctrl advance", 12'h424, 32'h2000);
        u_uhl_engine_model.ev(1, 32'h0);
        rd_chk("ctrl end idle", 12'h424, 32'h0);
        apb(1'b1, 12'h408, 32'h6);
        u_uhl_engine_model.ev(1, 32'h0);
        rd_chk("ctrl reload", 12'h424, 32'hFFFF_FFF0);
        rd_chk("ctrl flag", 12'h408, 32'h4);
        u_uhl_engine_model.ev(2, 32'h7777);
        rd_chk("bulk advance", 12'h42C, 32'h7770);
        u_uhl_engine_model.ev(2, 32'h0);
        rd_chk("bulk reload", 12'h42C, 32'h5A50);
        rd_chk("bulk flag", 12'h408, 32'h0);
        chk("bulk out", bulk_ptr, 32'h0000_5A50);
        u_uhl_engine_model.ev(2, 32'h0);
        rd_chk("bulk end idle", 12'h42C, 32'h0);
    endtask
    task automatic t_done;
        u_uhl_engine_model.ev(3, 32'h1108, 1'b1, 32'h2200);
        rd_chk("done head", 12'h430, 32'h2200);
        chk("td link", u_uhl_engine_model.lnk, 32'h1100);
        u_uhl_engine_model.ev(4, 32'h0);
        rd_chk("done cleared", 12'h430, 32'h0);
        chk("write-back", u_uhl_engine_model.area_val, 32'h2200);
        rd_chk("written flag", 12'h40C, 32'h2);
        u_uhl_engine_model.ev(4, 32'h0);
        wr_chk("flag clear", 12'h40C, 32'h2, 32'h0);
        chk("one write-back", u_uhl_engine_model.area_cnt, 32'h1);
    endtask
    task automatic t_frame;
        wr_chk("interval", 12'h434, 32'h8005_0005, 32'h8005_0005);
        repeat (5) u_uhl_engine_model.ev(5, 32'h0);
        rd_chk("remaining", 12'h438, 32'h8000_0001);
        chk("largest", {17'h0, largest_packet_count}, 32'h5);
        repeat (2) u_uhl_engine_model.ev(5, 32'h0);
        rd_chk("reloaded", 12'h438, 32'h8000_0005);
        chk("frames", u_uhl_engine_model.sof_cnt, 32'h2);
        apb(1'b1, 12'h408, 32'h1);
        rd_chk("soft reset", 12'h434, 32'h0000_2EDF);
    endtask

    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_masks();
        t_gate();
        t_lists();
        t_done();
        t_frame();
        conclude();
    end
endmodule
